// *** testbench/reset_pin_model.sv ***
`default_nettype none
module reset_pin_model (
  input wire logic drive_n,
  input wire logic drive_oe,
  input wire logic pullup_en,
  input wire logic ext_low,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // pin resolution
  // ----------------
  // board resistor keeps the line high once both parties let go
  assign pin_level = ((drive_oe && !drive_n) || ext_low) ? 1'b0 : 1'b1;
endmodule : reset_pin_model
`default_nettype wire

// *** testbench/test_reset_supervisor_controller.sv ***
`default_nettype none
module test_reset_supervisor_controller;
  timeunit 1ns;
  timeprecision 100ps;
  import rst_sup_pkg::*;
  localparam int PCYC = 8;
  logic clk, reset_pin_n, supply_above_lo, supply_above_hi, backup_supply_on;
  logic [2:0] brownout_threshold_opt;
  logic in_stop2, in_standby, in_shutdown, standby_exit, shutdown_exit;
  logic standby_entry, stop_entry, shutdown_entry, ext_low;
  logic standby_entry_reset_opt_n, stop_entry_reset_opt_n, shutdown_entry_reset_opt_n;
  logic window_watchdog, independent_watchdog, firewall_event, core_sw_reset_request;
  logic reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, reset_pin_pullup_en;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, reset_vector_addr, rd_val;
  logic reg_wr, reg_rd, power_reset_n, core_reset_n, system_reset_n, backup_reset_n;
  logic mode_entry_blocked, brownout_sample_en;
  int failures, cmp_count, k;
  // ----------------
  // design and pin
  // ----------------
  reset_supervisor_controller #(.PULSE_CYCLES(PCYC), .SAMPLE_CYCLES(16)) uut (
    .clk, .reset_pin_n, .supply_above_lo, .supply_above_hi, .backup_supply_on,
    .brownout_threshold_opt, .in_stop2, .in_standby, .in_shutdown, .standby_exit,
    .shutdown_exit, .standby_entry, .stop_entry, .shutdown_entry,
    .standby_entry_reset_opt_n, .stop_entry_reset_opt_n, .shutdown_entry_reset_opt_n,
    .window_watchdog, .independent_watchdog, .firewall_event, .core_sw_reset_request,
    .reset_pin_n_in, .reset_pin_n_out, .reset_pin_n_oe, .reset_pin_pullup_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_reset_n, .core_reset_n,
    .system_reset_n, .backup_reset_n, .mode_entry_blocked, .brownout_sample_en,
    .reset_vector_addr);
  reset_pin_model pin (.drive_n(reset_pin_n_out), .drive_oe(reset_pin_n_oe),
    .pullup_en(reset_pin_pullup_en), .ext_low(ext_low), .pin_level(reset_pin_n_in));
  // ----------------
  // helpers
  // ----------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic await(ref logic s, input logic v, input int lim);
    for (int n = 0; s !== v; n++) begin
      if (n == lim) begin
        failures++;
        $display("Error at %0t: wait timed out", $time);
        final_report();
      end
      step();
    end
  endtask : await
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd
  function automatic logic [31:0] exp_flag(input int s);
    case (s)
      0: return 32'h0000_0001 << F_WINDOW_WD;
      1: return 32'h0000_0001 << F_INDEP_WD;
      2: return 32'h0000_0001 << F_FW;
      3: return 32'h0000_0001 << F_SW;
      7: return 32'h0000_0001 << F_OBL;
      default: return 32'h0000_0001 << F_LP;
    endcase
  endfunction : exp_flag
  // one internal source, then pulse length, pin drive and flag
  task automatic run_src(input int s);
    int n;
    @(posedge clk);
    case (s)
      0: window_watchdog <= 1'b1;
      1: independent_watchdog <= 1'b1;
      2: firewall_event <= 1'b1;
      3: core_sw_reset_request <= 1'b1;
      4: stop_entry <= 1'b1;
      5: standby_entry <= 1'b1;
      6: shutdown_entry <= 1'b1;
      default: wr(REG_FLASH_CTRL, 32'h0000_0001 << OPTION_RELOAD_BIT);
    endcase
    @(posedge clk);
    {window_watchdog, independent_watchdog, firewall_event} <= '0;
    {core_sw_reset_request, stop_entry, standby_entry, shutdown_entry} <= '0;
    await(reset_pin_n_oe, 1'b1, 6);
    for (n = 0; reset_pin_n_oe === 1'b1 && n < 200; n++) begin
      chk(reset_pin_pullup_en, 0, "pull-up while driving");
      chk(system_reset_n, 0, "system reset during pulse");
      step();
    end
    chk({31'h0, n >= PCYC - 1}, 1, "pulse length");
    await(system_reset_n, 1'b1, 20);
    rd(REG_FLAGS);
    chk(rd_val, exp_flag(s), "source flag");
    rd(REG_FLASH_CTRL);
    chk(rd_val, 0, "loader bit after reset");
    wr(REG_CTRL, 32'h0000_0001);
    $display("source test %0d done", s);
  endtask : run_src
  // ----------------
  // sequence
  // ----------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200us;
    failures++;
    $display("Error at %0t: run timed out", $time);
    final_report();
  end
  initial begin
    {reset_pin_n, in_stop2, in_standby, in_shutdown, standby_exit, shutdown_exit} = '0;
    {standby_entry, stop_entry, shutdown_entry, ext_low, reg_wr, reg_rd} = '0;
    {window_watchdog, independent_watchdog, firewall_event, core_sw_reset_request} = '0;
    {standby_entry_reset_opt_n, stop_entry_reset_opt_n, shutdown_entry_reset_opt_n} = '0;
    {supply_above_lo, supply_above_hi, backup_supply_on} = 3'h7;
    {reg_addr, reg_wdata, brownout_threshold_opt} = '0;
    failures = 0;
    cmp_count = 0;
    void'($urandom(32'h0000_06f7));
    repeat (3) @(posedge clk);
    reset_pin_n <= 1'b1;
    await(power_reset_n, 1'b1, 10);
    chk(reset_vector_addr, RESET_VECTOR_ADDR, "vector");
    wr(REG_CTRL, 32'h0000_0001);
    rd(4'hf);
    chk(rd_val, 0, "unmapped read");
    for (k = 0; k < 8; k++) run_src(k);
    repeat (4) run_src($urandom_range(7));
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (30) step();
    chk(system_reset_n, 0, "held by pin");
    ext_low <= 1'b0;
    await(system_reset_n, 1'b1, 20);
    rd(REG_FLAGS);
    chk(rd_val, 32'h0000_0001 << F_PIN, "pin flag");
    $display("pin test done");
    {supply_above_lo, supply_above_hi} <= 2'h0;
    repeat (3) step();
    chk(power_reset_n, 0, "brownout");
    supply_above_lo <= 1'b1;
    repeat (10) step();
    chk(power_reset_n, 0, "below upper limit");
    supply_above_hi <= 1'b1;
    await(power_reset_n, 1'b1, 10);
    $display("brownout test done");
    wr(REG_BACKUP_CTRL, 32'h0000_0001 << BACKUP_RST_BIT);
    step();
    chk(backup_reset_n, 0, "backup reset");
    wr(REG_BACKUP_CTRL, 32'h0000_0000);
    await(backup_reset_n, 1'b1, 4);
    $display("backup test done");
    final_report();
  end
endmodule : test_reset_supervisor_controller
`default_nettype wire

// *** verilog/reset_supervisor_controller.sv ***
`default_nettype none
module reset_supervisor_controller #(
  parameter int PULSE_CYCLES = rst_sup_pkg::PULSE_CYC,
  parameter int SAMPLE_CYCLES = rst_sup_pkg::SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic reset_pin_n,
  // supply comparators, already digital
  input wire logic supply_above_lo,
  input wire logic supply_above_hi,
  input wire logic backup_supply_on,
  input wire logic [2:0] brownout_threshold_opt,
  // power mode
  input wire logic in_stop2,
  input wire logic in_standby,
  input wire logic in_shutdown,
  input wire logic standby_exit,
  input wire logic shutdown_exit,
  input wire logic standby_entry,
  input wire logic stop_entry,
  input wire logic shutdown_entry,
  input wire logic standby_entry_reset_opt_n,
  input wire logic stop_entry_reset_opt_n,
  input wire logic shutdown_entry_reset_opt_n,
  // internal reset sources
  input wire logic window_watchdog,
  input wire logic independent_watchdog,
  input wire logic firewall_event,
  input wire logic core_sw_reset_request,
  // reset pin
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe,
  output logic reset_pin_pullup_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // reset outputs
  output logic power_reset_n,
  output logic core_reset_n,
  output logic system_reset_n,
  output logic backup_reset_n,
  output logic mode_entry_blocked,
  output logic brownout_sample_en,
  output logic [31:0] reset_vector_addr
);
  import rst_sup_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] supply_ok_sync;
    logic supply_ok;
    logic por_pending;
    logic [2:0] level;
    logic backup_was_on;
    rst_state_t st;
    logic [31:0] pulse_cnt;
    logic [31:0] sample_cnt;
    logic [NFLAGS-1:0] flags;
    logic ulp_en;
    logic [31:0] flash_ctrl;
    logic backup_sw_rst;
    logic bkp_rst;
    logic wake_rst;
    logic [31:0] rdata;
  } state_t;

  state_t q, d;

  localparam state_t RESET_STATE = '{
    pin_sync: 2'h3, supply_ok_sync: 2'h0, supply_ok: 1'b0, por_pending: 1'b1,
    level: THRESHOLD_LEVEL_RST, backup_was_on: 1'b0, st: ST_IDLE,
    pulse_cnt: 32'h0000_0000, sample_cnt: 32'h0000_0000,
    flags: '0, ulp_en: 1'b0, flash_ctrl: 32'h0000_0000,
    backup_sw_rst: 1'b0, bkp_rst: 1'b1, wake_rst: 1'b0,
    rdata: 32'h0000_0000};

  logic pin_low;
  logic sampled_mode;
  logic sample_tick;
  logic lp_event;
  logic obl_event;
  logic [NFLAGS-1:0] src;
  logic internal_src;
  logic sys_rst_active;

  // ----------------------------------------
  // reset source collection
  // ----------------------------------------
  always_comb begin
    pin_low = ~q.pin_sync[1];
    sampled_mode = q.ulp_en & (in_stop2 | in_standby | in_shutdown); // [R05]
    sample_tick = (q.sample_cnt == 32'h0000_0000);
    lp_event = (standby_entry & ~standby_entry_reset_opt_n)
             | (stop_entry & ~stop_entry_reset_opt_n)
             | (shutdown_entry & ~shutdown_entry_reset_opt_n); // [R18]
    obl_event = reg_wr && reg_addr == REG_FLASH_CTRL && reg_wdata[OPTION_RELOAD_BIT]; // [R19]
    src = '0;
    // only lows seen from idle: the echo of our own pulse is not a pin reset
    src[F_PIN] = pin_low & (q.st == ST_IDLE); // [R14]
    src[F_WINDOW_WD] = window_watchdog; // [R11]
    src[F_INDEP_WD] = independent_watchdog;
    src[F_FW] = firewall_event;
    src[F_SW] = core_sw_reset_request; // [R17]
    src[F_LP] = lp_event;
    src[F_OBL] = obl_event;
    src[F_BROWNOUT] = ~q.supply_ok;
    src[F_WAKE] = standby_exit | shutdown_exit; // [R07]
    internal_src = |src[NFLAGS-1:1];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.pin_sync = {q.pin_sync[0], reset_pin_n_in}; // [R23]
    d.supply_ok_sync = {q.supply_ok_sync[0], supply_above_hi};
    d.wake_rst = standby_exit | shutdown_exit; // [R09]
    d.por_pending = 1'b0;
    // option level caught once after release
    if (q.por_pending) begin
      d.level = (brownout_threshold_opt < THRESHOLD_LEVELS) ? brownout_threshold_opt
              : THRESHOLD_LEVEL_RST; // [R02]
    end
    // supervisor never disabled except in shutdown
    if (in_shutdown && !q.ulp_en) begin
      d.sample_cnt = 32'h0000_0000;
    end else begin // [R01]
      if (sampled_mode) begin
        d.sample_cnt = sample_tick ? 32'(SAMPLE_CYCLES - 1) : q.sample_cnt - 32'h0000_0001;
      end else begin
        d.sample_cnt = 32'h0000_0000;
      end
      if (!sampled_mode || sample_tick) begin // [R06]
        if (!q.supply_ok && q.supply_ok_sync[1]) begin
          d.supply_ok = 1'b1; // [R04]
        end else if (q.supply_ok && !supply_above_lo) begin
          d.supply_ok = 1'b0; // [R03]
        end
      end
    end
    // backup-domain power-on detection
    d.backup_was_on = backup_supply_on | q.supply_ok;
    d.bkp_rst = q.backup_sw_rst | ((backup_supply_on | q.supply_ok) & ~q.backup_was_on); // [R21]
    // pulse generator for pin
    unique case (q.st)
      ST_IDLE: begin
        if (internal_src) begin
          d.st = ST_PULSE;
          d.pulse_cnt = 32'(PULSE_CYCLES - 1);
        end else if (pin_low) begin
          d.st = ST_EXT;
        end
      end
      ST_PULSE: begin
        if (internal_src) begin
          d.pulse_cnt = 32'(PULSE_CYCLES - 1);
        end else if (q.pulse_cnt != 32'h0000_0000) begin
          d.pulse_cnt = q.pulse_cnt - 32'h0000_0001; // [R13]
        end else begin
          d.st = pin_low ? ST_EXT : ST_IDLE;
        end
      end
      ST_EXT: begin
        if (internal_src) begin
          d.st = ST_PULSE;
          d.pulse_cnt = 32'(PULSE_CYCLES - 1);
        end else if (!pin_low) begin
          d.st = ST_IDLE; // [R14]
        end
      end
    endcase
    // flags survive system reset, set wins over clear
    if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLEAR_BIT]) begin
      d.flags = '0;
    end
    d.flags = d.flags | src; // [R12] [R10]
    if (reg_wr && reg_addr == REG_CTRL) begin
      d.ulp_en = reg_wdata[CTRL_ULP_BIT];
    end
    if (reg_wr && reg_addr == REG_FLASH_CTRL) begin
      d.flash_ctrl = reg_wdata;
    end
    if (reg_wr && reg_addr == REG_BACKUP_CTRL) begin
      d.backup_sw_rst = reg_wdata[BACKUP_RST_BIT]; // [R20]
    end
    if (q.st != ST_IDLE) begin
      d.flash_ctrl = 32'h0000_0000;
    end
    d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_FLAGS: d.rdata = 32'(q.flags);
        REG_CTRL: d.rdata = {30'h0000_0000, q.ulp_en, 1'b0};
        REG_FLASH_CTRL: d.rdata = q.flash_ctrl;
        REG_BACKUP_CTRL: d.rdata = {15'h0000, q.backup_sw_rst, 16'h0000};
        REG_STATUS: d.rdata = {26'h0000_000, q.level, sampled_mode, q.supply_ok, pin_low};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_pin_n) begin
    if (!reset_pin_n) begin
      q <= RESET_STATE; // [R23]
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sys_rst_active = (q.st != ST_IDLE);
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe = (q.st == ST_PULSE); // [R13]
  assign reset_pin_pullup_en = (q.st != ST_PULSE); // [R15]
  assign power_reset_n = q.supply_ok & ~q.wake_rst; // [R07] [R08]
  assign core_reset_n = power_reset_n & ~sys_rst_active; // [R09]
  assign system_reset_n = core_reset_n; // [R10]
  assign backup_reset_n = ~q.bkp_rst; // [R22]
  assign mode_entry_blocked = lp_event; // [R18]
  assign brownout_sample_en = ~in_shutdown | q.ulp_en;
  assign reset_vector_addr = RESET_VECTOR_ADDR; // [R16]
  assign reg_rdata = q.rdata;

  // ----------------------------------------
  // checks: supply supervisor
  // ----------------------------------------
  a_supervisor_live: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R01]
    !in_shutdown |-> brownout_sample_en) else $error("supervisor off outside shutdown");

  a_level_legal: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R02]
    q.level < THRESHOLD_LEVELS) else $error("threshold level out of range");

  a_power_hold: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R02]
    !q.supply_ok |-> !power_reset_n) else $error("released below threshold");

  a_brownout_assert: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R03]
    (q.supply_ok && !supply_above_lo && !sampled_mode && !in_shutdown) |=> !power_reset_n)
    else $error("brownout missed");

  a_release_upper: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R04]
    $rose(q.supply_ok) |-> $past(q.supply_ok_sync[1])) else $error("released below upper limit");

  a_sample_period: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R05]
    (sampled_mode && sample_tick) |=> (q.sample_cnt == 32'(SAMPLE_CYCLES - 1)))
    else $error("sample period not reloaded");

  a_sample_hold: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R06]
    (sampled_mode && !sample_tick) |=> $stable(q.supply_ok)) else $error("evaluated off tick");

  // ----------------------------------------
  // checks: power and system reset
  // ----------------------------------------
  a_wake_power: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R07]
    (standby_exit || shutdown_exit) |=> !power_reset_n) else $error("wake reset missed");

  a_power_core: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R08]
    !power_reset_n |-> !core_reset_n) else $error("core out of reset in power reset");

  a_wake_flag: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R09]
    (standby_exit || shutdown_exit) |=> q.flags[F_WAKE]) else $error("wake flag missed");

  a_core_system: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R10]
    !core_reset_n |-> !system_reset_n) else $error("system out of reset in core reset");

  a_flags_kept: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R10]
    !(reg_wr && reg_addr == REG_CTRL) |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
    else $error("flag lost without clear");

  a_source_reset: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R11]
    (window_watchdog || independent_watchdog || firewall_event) |=> !system_reset_n)
    else $error("watchdog or firewall reset missed");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R12]
    (q.flags[F_WINDOW_WD] && !(reg_wr && reg_addr == REG_CTRL)) |=> q.flags[F_WINDOW_WD])
    else $error("flag dropped");

  a_read_idle: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R12]
    !$past(reg_rd) |-> (reg_rdata == 32'h0000_0000)) else $error("read data outside slot");

  a_sw_reset: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R17]
    core_sw_reset_request |=> !system_reset_n ##0 q.flags[F_SW]) else $error("sw reset lost");

  // ----------------------------------------
  // checks: reset pin
  // ----------------------------------------
  a_pin_held_min: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R13]
    $rose(reset_pin_n_oe) |-> reset_pin_n_oe [*8]) else $error("pin pulse too short");

  a_pulse_drive: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R13]
    (q.st == ST_PULSE) |-> (reset_pin_n_oe && !reset_pin_n_out)) else $error("pin not driven");

  a_pulse_reload: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R13]
    internal_src |=> (q.pulse_cnt == 32'(PULSE_CYCLES - 1))) else $error("pulse not rearmed");

  a_pulse_run: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R13]
    (q.st == ST_PULSE && q.pulse_cnt != 32'h0000_0000) |=> (q.st == ST_PULSE))
    else $error("pulse cut short");

  a_ext_hold: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R14]
    (!q.pin_sync[1] && !internal_src) |=> !system_reset_n) else $error("ext reset not held");

  a_ext_flag: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R14]
    (q.st == ST_IDLE && pin_low) |=> q.flags[F_PIN]) else $error("pin flag missed");

  a_pullup_off: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R15]
    reset_pin_n_oe |-> !reset_pin_pullup_en) else $error("pullup on while driving");

  a_pullup_idle: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R15]
    !reset_pin_n_oe |-> reset_pin_pullup_en) else $error("pullup off while released");

  a_pin_sync: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R23]
    q.pin_sync[1] == $past(q.pin_sync[0])) else $error("pin synchroniser skipped");

  // ----------------------------------------
  // checks: other reset causes
  // ----------------------------------------
  a_vector_fixed: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R16]
    reset_vector_addr == RESET_VECTOR_ADDR) else $error("vector moved");

  a_lp_block: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R18]
    (stop_entry && !stop_entry_reset_opt_n) |-> mode_entry_blocked ##1 reset_pin_n_oe)
    else $error("lp security reset missed");

  a_lp_standby: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R18]
    (standby_entry && !standby_entry_reset_opt_n) |-> mode_entry_blocked)
    else $error("standby entry not blocked");

  a_lp_shutdown: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R18]
    (shutdown_entry && !shutdown_entry_reset_opt_n) |-> mode_entry_blocked)
    else $error("shutdown entry not blocked");

  a_obl_reset: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R19]
    obl_event |=> reset_pin_n_oe) else $error("loader reset missed");

  a_loader_clear: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R19]
    (q.st != ST_IDLE) |=> (q.flash_ctrl == 32'h0000_0000)) else $error("loader bit kept");

  a_backup_sw: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R20]
    q.backup_sw_rst |=> !backup_reset_n) else $error("backup reset missed");

  a_backup_powerup: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R21]
    (backup_supply_on && !q.backup_was_on) |=> !backup_reset_n)
    else $error("backup power-up reset missed");

  a_backup_out: assert property (@(posedge clk) disable iff (!reset_pin_n) // [R22]
    q.bkp_rst |-> !backup_reset_n) else $error("backup reset not driven");
endmodule : reset_supervisor_controller
`default_nettype wire

// *** verilog/rst_sup_pkg.sv ***
// Overview of operation
// R01: brownout supervisor runs in every mode but shutdown; no disable control exists.
// R02: threshold picked from five option levels; hold reset until supply reaches it.
// R03: supply falling below selected threshold asserts device reset.
// R04: release only once supply passes upper (hysteresis) limit of threshold.
// R05: sampled monitor enable replaces continuous watch by periodic samples in deep modes.
// R06: in sampled mode a drop wholly between samples may go unseen.
// R07: power reset on brownout and on exit from standby or shutdown.
// R08: brownout-type reset clears all registers except backup domain.
// R09: standby/shutdown exit resets core domain; rtc, wakeup, watchdog, mode control kept.
// R10: system reset clears all but reset-source flags and backup domain.
// R11: system reset from pin, watchdogs, firewall, software, low-power, loader, brownout.
// R12: one sticky flag per reset cause, readable by software.
// R13: internal sources drive reset pin low at least 20 us and through delay phase.
// R14: external low on pin keeps internal reset asserted while pin is low.
// R15: pull-up switched off while an internal source drives the pin.
// R16: reset handler vector fetched from fixed address 0x0000_0004.
// R17: core software reset request bit causes a system reset.
// R18: cleared entry option bit makes mode entry reset the device instead.
// R19: option reload trigger, bit 27 of flash control, raises a loader reset.
// R20: backup domain software reset bit raises backup-domain reset.
// R21: backup reset on supply power-up when both supplies were off.
// R22: backup reset touches only low-speed osc, rtc, backup regs, backup control.
// R23: sources synchronised; reset asserts asynchronously, releases synchronously.
`default_nettype none
package rst_sup_pkg;
  localparam int CLK_MHZ = 200;
  localparam int PULSE_MIN_US = 20;
  localparam int PULSE_CYC = PULSE_MIN_US * CLK_MHZ;
  localparam int SAMPLE_MS = 12;
  localparam int SAMPLE_CYC = SAMPLE_MS * 1000 * CLK_MHZ;
  localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
  localparam int OPTION_RELOAD_BIT = 27;
  localparam logic [2:0] THRESHOLD_LEVELS = 3'h5;
  localparam logic [2:0] THRESHOLD_LEVEL_RST = 3'h0;
  // register indices
  localparam logic [3:0] REG_FLAGS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_FLASH_CTRL = 4'h2;
  localparam logic [3:0] REG_BACKUP_CTRL = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // flag bit positions
  localparam int F_PIN = 0;
  localparam int F_WINDOW_WD = 1;
  localparam int F_INDEP_WD = 2;
  localparam int F_FW = 3;
  localparam int F_SW = 4;
  localparam int F_LP = 5;
  localparam int F_OBL = 6;
  localparam int F_BROWNOUT = 7;
  localparam int F_WAKE = 8;
  localparam int NFLAGS = 9;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_ULP_BIT = 1;
  localparam int BACKUP_RST_BIT = 16;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PULSE,
    ST_EXT
  } rst_state_t;
endpackage : rst_sup_pkg
`default_nettype wire
